// >>> dv/sfc_spi_master.sv
/*
 * SPI master model for the serial memory command engine.
 * Assumes the bench calls frame() and watches rxTgl for answers.
 */
`timescale 1ns/1ns
module sfc_spi_master (
    input  wire logic       serOut,
    input  wire logic       serOutEn,
    output logic            chipSelN,
    output logic            serClk,
    output logic            serIn,
    output logic [7:0]      rxByte,
    output logic            rxTgl
);
    logic lastSo;
    logic soLine;

    // Released line shows the inverse of its last driven level
    always @(serOut or serOutEn) begin
        if (serOutEn) lastSo = serOut;
    end
    assign soLine = serOutEn ? serOut : ~lastSo;

    // Idle pins at time zero
    initial begin
        chipSelN = 1'b1;
        serClk = 1'b0;
        serIn = 1'b0;
        rxByte = 8'h00;
        rxTgl = 1'b0;
        lastSo = 1'b0;
    end

    // One select cycle; bytes flagged in rxMask are returned
    task automatic frame(input bit m3, input logic [7:0] tx[$],
                         input logic [31:0] rxMask);
        logic [7:0] rx;
        serClk <= m3;
        #20;
        chipSelN <= 1'b0;
        #40;
        foreach (tx[i]) begin
            for (int b = 7; b >= 0; b--) begin
                serClk <= 1'b0;
                serIn <= tx[i][b];
                #62;
                rx[b] = soLine;
                serClk <= 1'b1;
                #63;
            end
            if (rxMask[i]) begin
                rxByte <= rx;
                rxTgl <= ~rxTgl;
            end
        end
        serClk <= m3;
        #30;
        chipSelN <= 1'b1;
        serIn <= ~serIn;
        #125;
    endtask
endmodule

// >>> dv/tb_top.sv
/*
 * Self-checking bench of the command engine: tracks latch, status
 * and array contents, queues expected answers, compares them.
 * Assumes the master model drives select, serial clock and serial input.
 */
`timescale 1ns/1ns
module tb_top;
    logic        clk_sys;
    logic        rst_n;
    logic        protectPinN;
    logic        chipSelN;
    logic        serClk;
    logic        serIn;
    logic        serOut;
    logic        serOutEn;
    logic [7:0]  rxByte;
    logic        rxTgl;
    int          n_errors = 0;
    int          total_checks = 0;
    logic [7:0]  expQ[$];
    logic [7:0]  memExp[int];
    logic        latch;
    logic        pinEn;
    logic [1:0]  guard;
    logic [15:0] lfsr = 16'h000C;

    always #5 clk_sys = ~clk_sys;

    sfc_command_engine i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .chipSelN(chipSelN),
        .serClk(serClk), .serIn(serIn), .protectPinN(protectPinN),
        .serOut(serOut), .serOutEn(serOutEn));

    sfc_spi_master i_master (
        .serOut(serOut), .serOutEn(serOutEn), .chipSelN(chipSelN),
        .serClk(serClk), .serIn(serIn), .rxByte(rxByte), .rxTgl(rxTgl));

    // Pseudo-random data bytes
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction

    task automatic check(input string name, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Each returned byte is compared with the oldest note
    always @(rxTgl) begin
        if ($time > 0) begin
            if (expQ.size() == 0) begin
                n_errors++;
                $display("[ERR] answer expected none seen %h", rxByte);
            end else begin
                check("answer", rxByte, expQ.pop_front());
            end
        end
    end

    task automatic cmd(input logic [7:0] op);
        i_master.frame(1'b0, '{op}, 32'h0);
        if (op == sfc_pkg::OP_SET_LATCH) latch = 1'b1;
        if (op == sfc_pkg::OP_CLEAR_LATCH) latch = 1'b0;
    endtask

    task automatic sread(input bit m3);
        expQ.push_back({pinEn, 3'h0, guard, latch, 1'b0});
        i_master.frame(m3, '{sfc_pkg::OP_STATUS_READ, rnd()}, 32'h2);
    endtask

    task automatic swrite(input logic [7:0] v);
        i_master.frame(1'b0, '{sfc_pkg::OP_STATUS_WRITE, v}, 32'h0);
        if (latch && !(pinEn && !protectPinN)) begin
            pinEn = v[7];
            guard = v[3:2];
        end
        latch = 1'b0;
    endtask

    function automatic bit guarded(input logic [10:0] a);
        return guard == 2'h1 ? a >= 11'h600 :
               guard == 2'h2 ? a >= 11'h400 : guard == 2'h3;
    endfunction

    task automatic mwrite(input logic [10:0] a, input int n);
        logic [7:0] tx[$];
        logic [7:0] d;
        bit stop;
        tx = '{sfc_pkg::OP_MEM_WRITE, {5'h1F, a[10:8]}, a[7:0]};
        stop = !latch;
        for (int k = 0; k < n; k++) begin
            d = rnd();
            tx.push_back(d);
            if (!stop && guarded(a)) stop = 1'b1;
            if (!stop) begin
                memExp[a] = d;
                a++;
            end
        end
        i_master.frame(1'b0, tx, 32'h0);
        latch = 1'b0;
    endtask

    task automatic mread(input logic [10:0] a, input int n, input bit m3);
        logic [7:0] tx[$];
        logic [31:0] mask;
        tx = '{sfc_pkg::OP_MEM_READ, {5'h15, a[10:8]}, a[7:0]};
        mask = 32'h0;
        for (int k = 0; k < n; k++) begin
            tx.push_back(rnd());
            expQ.push_back(memExp[a]);
            mask[3 + k] = 1'b1;
            a++;
        end
        i_master.frame(m3, tx, mask);
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard
    initial begin
        #900000;
        n_errors++;
        $display("[ERR] run time expected end seen none");
        complete_run();
    end

    // Main sequence
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        protectPinN = 1'b1;
        latch = 1'b0;
        pinEn = 1'b0;
        guard = 2'h0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sread(1'b0);
        cmd(sfc_pkg::OP_SET_LATCH);
        sread(1'b1);
        cmd(sfc_pkg::OP_CLEAR_LATCH);
        sread(1'b0);
        cmd(8'hA5);
        sread(1'b0);
        swrite(8'h8E);
        sread(1'b0);
        cmd(sfc_pkg::OP_SET_LATCH);
        mwrite(11'h5FE, 4);
        for (int g = 0; g < 4; g++) begin
            cmd(sfc_pkg::OP_SET_LATCH);
            swrite({6'h00, g[1:0]} << 2 | 8'h03);
            sread(g[0]);
            cmd(sfc_pkg::OP_SET_LATCH);
            mwrite(11'h5FF, 2);
            mread(11'h5FE, 4, g[0]);
        end
        cmd(sfc_pkg::OP_SET_LATCH);
        swrite(8'h80);
        @(posedge clk_sys) protectPinN <= 1'b0;
        cmd(sfc_pkg::OP_SET_LATCH);
        swrite(8'h0C);
        sread(1'b0);
        cmd(sfc_pkg::OP_SET_LATCH);
        mwrite(11'h7FE, 4);
        mread(11'h7FE, 4, 1'b1);
        @(posedge clk_sys) protectPinN <= 1'b1;
        cmd(sfc_pkg::OP_SET_LATCH);
        swrite(8'h04);
        sread(1'b0);
        mwrite(11'h000, 1);
        mread(11'h000, 1, 1'b0);
        cmd(sfc_pkg::OP_SET_LATCH);
        @(posedge clk_sys) rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        latch = 1'b0;
        repeat (3) @(posedge clk_sys);
        sread(1'b0);
        for (int i = 0; i < 100 && expQ.size() > 0; i++)
            @(posedge clk_sys);
        if (expQ.size() > 0) begin
            n_errors++;
            $display("[ERR] answers expected %0d seen 0", expQ.size());
        end
        complete_run();
    end
endmodule

// >>> src/sfc_command_engine.sv
/*
 * Command engine of a 2K x 8 serial memory acting as an SPI slave:
 * opcode decode, write latch, status byte, guarded burst access.
 * Assumes the SPI pins are asynchronous to clk_sys and the serial
 * clock is at most a tenth of clk_sys; the bench joins the output
 * and its enable into the shared data wire.
 */
`timescale 1ns/1ns
// Functional notes
// - Opcodes 06 set, 04 clear, 05 status read
// - Opcodes 01 status write, 03 read, 02 write
// - Latch cleared after power-up
// - Set-latch opcode sets latch, shown bit 1
// - Status write clears latch flag at select rise
// - Select rise clears latch after writes
// - Clear-latch leaves flag reading zero
// - Status layout: 7 pin, 3:2 guard, 1 latch
// - Guard bits survive reset, zero at power-up
// - Guard codes protect upper quarter, half, all
// - Protect pin low blocks status write if enabled
// - Protect pin never blocks array writes
// - Status read returns exactly one byte
// - Two address bytes, low 11 bits used
// - Address increments per byte, wraps to zero
// - Each write byte committed after eighth bit
// - Protected address stops increment, drops data
// - Write command ends only at select rise
// - Read data MSB first, input ignored
// - Select rise ends read, output released
// - Array write needs latch and unguarded address
// - Sample on rise, shift out on fall
// - Invalid opcode ignored until next select
// - Deselected: input ignored, output released
module sfc_command_engine (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic chipSelN,
    input  wire logic serClk,
    input  wire logic serIn,
    input  wire logic protectPinN,
    output logic      serOut,
    output logic      serOutEn
);
    localparam int FW = sfc_pkg::ADDR_W + sfc_pkg::DATA_W;

    logic [3:0]              pinS;
    logic                    csS;
    logic                    sckS;
    logic                    siS;
    logic                    wpS;
    logic                    csPrev;
    logic                    sckPrev;
    logic                    spiMode3;
    logic                    seenRise;
    logic                    sckRise;
    logic                    sckFall;
    logic                    csRise;
    logic                    selectStart;
    sfc_pkg::sfc_state_t     state;
    sfc_pkg::sfc_state_t     next_state;
    logic [2:0]              bitCnt;
    logic                    byteEnd;
    logic [6:0]              rxShift;
    logic [7:0]              rxByte;
    logic [7:0]              lastOp;
    logic                    opDone;
    logic                    addrSecond;
    logic [10:0]             addr;
    logic                    stopped;
    logic                    writeLatch;
    logic                    pinProtect = 1'b0;
    logic [1:0]              blockGuard = sfc_pkg::GUARD_RESET;
    logic [7:0]              statusByte;
    logic [10:0]             guardBase;
    logic                    isGuarded;
    logic                    wrAllowed;
    logic                    wrPush;
    logic                    wrRefuse;
    logic                    statusWrOk;
    logic                    statusDone;
    logic                    latchClear;
    logic                    advance;
    logic [7:0]              memArray [sfc_pkg::MEM_DEPTH];
    logic [10:0]             loadAddr;
    logic                    txLoad;
    logic [7:0]              txSrc;
    logic [7:0]              txShift;
    logic                    fifoInReady;
    logic                    fifoOutValid;
    logic                    fifoOutReady;
    logic [FW-1:0]           fifoOut;

    // Pin levels cross into clk_sys
    sfc_sync #(
        .W       (4),
        .RST_VAL (sfc_pkg::PIN_RESET)
    ) uSync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       ({chipSelN, serClk, serIn, protectPinN}),
        .q       (pinS)
    );

    assign csS  = pinS[3];
    assign sckS = pinS[2];
    assign siS  = pinS[1];
    assign wpS  = pinS[0];

    // Edge detection on synchronised pins
    assign selectStart = !csS && (state == sfc_pkg::S_IDLE);
    assign csRise      = csS && !csPrev;
    assign sckRise     = !csS && sckS && !sckPrev;
    assign sckFall     = !csS && !sckS && sckPrev
                       && (seenRise || !spiMode3);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            csPrev  <= 1'b1;
            sckPrev <= 1'b0;
        end else begin
            csPrev  <= csS;
            sckPrev <= sckS;
        end
    end

    // Mode taken from clock level at selection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            spiMode3 <= 1'b0;
            seenRise <= 1'b0;
        end else if (selectStart) begin
            spiMode3 <= sckS;
            seenRise <= 1'b0;
        end else if (sckRise) begin
            seenRise <= 1'b1;
        end
    end

    // Byte assembly, MSB first
    assign rxByte  = {rxShift, siS};
    assign byteEnd = sckRise && (bitCnt == sfc_pkg::BIT_LAST);
    assign opDone  = byteEnd && (state == sfc_pkg::S_OPCODE);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt  <= '0;
            rxShift <= '0;
        end else if (state == sfc_pkg::S_IDLE) begin
            bitCnt  <= '0;
        end else if (sckRise) begin
            bitCnt  <= bitCnt + 1'b1;
            rxShift <= rxByte[6:0];
        end
    end

    // Command sequencing
    always_comb begin
        next_state = state;
        if (csS) begin
            next_state = sfc_pkg::S_IDLE;
        end else if (state == sfc_pkg::S_IDLE) begin
            next_state = sfc_pkg::S_OPCODE;
        end else if (byteEnd) begin
            case (state)
                sfc_pkg::S_OPCODE: begin
                    case (rxByte)
                        sfc_pkg::OP_STATUS_READ:
                            next_state = sfc_pkg::S_STOUT;
                        sfc_pkg::OP_STATUS_WRITE:
                            next_state = sfc_pkg::S_SWRITE;
                        sfc_pkg::OP_MEM_READ,
                        sfc_pkg::OP_MEM_WRITE:
                            next_state = sfc_pkg::S_ADDR;
                        default:
                            next_state = sfc_pkg::S_IGNORE;
                    endcase
                end
                sfc_pkg::S_ADDR: begin
                    if (addrSecond && lastOp == sfc_pkg::OP_MEM_READ) begin
                        next_state = sfc_pkg::S_RDATA;
                    end else if (addrSecond) begin
                        next_state = sfc_pkg::S_WDATA;
                    end
                end
                sfc_pkg::S_SWRITE: next_state = sfc_pkg::S_IGNORE;
                sfc_pkg::S_STOUT:  next_state = sfc_pkg::S_IGNORE;
                default:           next_state = state;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= sfc_pkg::S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Opcode and address capture
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lastOp     <= '0;
            addrSecond <= 1'b0;
        end else if (state == sfc_pkg::S_IDLE) begin
            addrSecond <= 1'b0;
        end else if (opDone) begin
            lastOp     <= rxByte;
        end else if (byteEnd && state == sfc_pkg::S_ADDR) begin
            addrSecond <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr <= sfc_pkg::ADDR_FIRST;
        end else if (byteEnd && state == sfc_pkg::S_ADDR) begin
            if (addrSecond) addr[7:0] <= rxByte;
            else addr[10:8] <= rxByte[2:0];
        end else if (advance) begin
            addr <= addr + 1'b1;
        end
    end

    // Guard range decode
    assign guardBase = (blockGuard == 2'h1) ? sfc_pkg::GUARD_QUARTER
                     : (blockGuard == 2'h2) ? sfc_pkg::GUARD_HALF
                     : sfc_pkg::GUARD_ALL;
    assign isGuarded = (blockGuard != 2'h0) && (addr >= guardBase);

    // Array write permission ignores the protect pin
    assign wrAllowed = writeLatch && !isGuarded;
    assign wrPush    = byteEnd && state == sfc_pkg::S_WDATA
                     && !stopped && wrAllowed;
    assign wrRefuse  = byteEnd && state == sfc_pkg::S_WDATA
                     && !(wrAllowed && fifoInReady);
    assign advance   = byteEnd && (state == sfc_pkg::S_RDATA
                     || (wrPush && fifoInReady));

    // Once refused, the rest of the burst is dropped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stopped <= 1'b0;
        end else if (state == sfc_pkg::S_IDLE) begin
            stopped <= 1'b0;
        end else if (wrRefuse) begin
            stopped <= 1'b1;
        end
    end

    // Write buffer between serial side and array
    sfc_fifo #(
        .WIDTH (FW),
        .DEPTH (sfc_pkg::FIFO_DEPTH)
    ) uFifo (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inValid  (wrPush),
        .inReady  (fifoInReady),
        .inData   ({addr, rxByte}),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOut)
    );

    // Drain stalls while a read fetch uses the array
    assign fifoOutReady = !txLoad;

    always_ff @(posedge clk_sys) begin
        if (fifoOutValid && fifoOutReady) begin
            memArray[fifoOut[FW-1:sfc_pkg::DATA_W]] <=
                fifoOut[sfc_pkg::DATA_W-1:0];
        end
    end

    // Write latch: set by opcode, cleared at select rise
    assign latchClear = csRise && (lastOp == sfc_pkg::OP_CLEAR_LATCH
                      || lastOp == sfc_pkg::OP_STATUS_WRITE
                      || lastOp == sfc_pkg::OP_MEM_WRITE);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            writeLatch <= 1'b0;
        end else if (opDone && rxByte == sfc_pkg::OP_SET_LATCH) begin
            writeLatch <= 1'b1;
        end else if (latchClear) begin
            writeLatch <= 1'b0;
        end
    end

    // Status write needs latch, blocked by enabled protect pin
    assign statusWrOk = writeLatch && !(pinProtect && !wpS);
    assign statusDone = byteEnd && state == sfc_pkg::S_SWRITE;

    // Guard settings keep their value across reset
    always_ff @(posedge clk_sys) begin
        if (statusDone && statusWrOk) begin
            pinProtect <= rxByte[sfc_pkg::ST_PIN_EN];
            blockGuard <= rxByte[sfc_pkg::ST_GUARD_HI:
                                 sfc_pkg::ST_GUARD_LO];
        end
    end

    // Status byte, unused bits read zero
    always_comb begin
        statusByte = sfc_pkg::STATUS_RESET;
        statusByte[sfc_pkg::ST_PIN_EN] = pinProtect;
        statusByte[sfc_pkg::ST_GUARD_HI:sfc_pkg::ST_GUARD_LO] = blockGuard;
        statusByte[sfc_pkg::ST_LATCH] = writeLatch;
    end

    // Transmit load at the end of a byte
    assign loadAddr = (state == sfc_pkg::S_ADDR) ? {addr[10:8], rxByte}
                    : addr + 1'b1;
    assign txLoad   = byteEnd && ((state == sfc_pkg::S_ADDR && addrSecond
                    && lastOp == sfc_pkg::OP_MEM_READ)
                    || state == sfc_pkg::S_RDATA
                    || (state == sfc_pkg::S_OPCODE
                    && rxByte == sfc_pkg::OP_STATUS_READ));
    assign txSrc    = (state == sfc_pkg::S_OPCODE) ? statusByte
                    : memArray[loadAddr];

    // Serial output shifts on falling clock edges
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txShift  <= '0;
            serOut   <= 1'b0;
            serOutEn <= 1'b0;
        end else if (csS) begin
            serOutEn <= 1'b0;
        end else if (txLoad) begin
            txShift  <= txSrc;
        end else if (sckFall && (state == sfc_pkg::S_RDATA
                     || state == sfc_pkg::S_STOUT)) begin
            serOut   <= txShift[7];
            txShift  <= {txShift[6:0], 1'b0};
            serOutEn <= 1'b1;
        end else if (sckFall) begin
            serOutEn <= 1'b0;
        end
    end

    // Checks on the engine's own behaviour
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_latch_set: assert property (
        opDone && rxByte == sfc_pkg::OP_SET_LATCH |=> writeLatch
        ##0 statusByte[sfc_pkg::ST_LATCH])
        else $error("set-latch opcode did not set latch");

    a_latch_clear: assert property (
        latchClear |=> !writeLatch [*2])
        else $error("latch not cleared at select rise");

    a_status_zero: assert property (
        statusByte[0] == 1'b0 && statusByte[6:4] == 3'h0)
        else $error("unused status bits not zero");

    a_latch_kept: assert property (
        statusDone |=> writeLatch == $past(writeLatch))
        else $error("status write altered latch");

    a_pin_blocks: assert property (
        statusDone && pinProtect && !wpS
        |=> $stable(blockGuard) && $stable(pinProtect))
        else $error("status write passed protect pin");

    a_commit_guard: assert property (
        wrPush |-> writeLatch && !isGuarded && !stopped)
        else $error("array write without permission");

    a_addr_wrap: assert property (
        advance && addr == sfc_pkg::ADDR_LAST
        |=> addr == sfc_pkg::ADDR_FIRST)
        else $error("address did not wrap");

    a_quiet_deselect: assert property (
        csS && $past(csS) |-> !serOutEn ##1 !serOutEn)
        else $error("output driven while deselected");

    a_invalid_quiet: assert property (
        opDone && next_state == sfc_pkg::S_IGNORE
        && rxByte != sfc_pkg::OP_STATUS_READ |=> !serOutEn)
        else $error("output driven after ignored opcode");

    a_stop_holds: assert property (
        stopped && !csS |=> stopped && !wrPush)
        else $error("write resumed after refusal");
endmodule

// >>> src/sfc_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock; DEPTH is a power of two.
 */
`timescale 1ns/1ns
module sfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wrPtr;
    logic [AW:0]      rdPtr;
    logic             push;
    logic             pop;

    // Full when pointers differ only in the wrap bit
    assign inReady  = (wrPtr ^ rdPtr) != {1'b1, {AW{1'b0}}};
    assign outValid = wrPtr != rdPtr;
    assign outData  = store[rdPtr[AW-1:0]];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    // Pointer update
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (push) wrPtr <= wrPtr + 1'b1;
            if (pop) rdPtr <= rdPtr + 1'b1;
        end
    end

    // Storage write
    always_ff @(posedge clk_sys) begin
        if (push) store[wrPtr[AW-1:0]] <= inData;
    end
endmodule

// >>> src/sfc_pkg.sv
/*
 * Shared constants and types of the serial memory command engine:
 * opcodes, status byte layout, guard boundaries, sizes and states.
 * Assumes every user refers to items as sfc_pkg::name.
 */
package sfc_pkg;

    // Opcodes, first byte of every select cycle
    localparam logic [7:0] OP_SET_LATCH    = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_READ     = 8'h03;
    localparam logic [7:0] OP_MEM_WRITE    = 8'h02;

    // Array geometry and buffer depth
    localparam int ADDR_W     = 11;
    localparam int DATA_W     = 8;
    localparam int MEM_DEPTH  = 2048;
    localparam int FIFO_DEPTH = 16;

    // Address limits and guard boundaries
    localparam logic [10:0] ADDR_LAST     = 11'h7FF;
    localparam logic [10:0] ADDR_FIRST    = 11'h000;
    localparam logic [10:0] GUARD_QUARTER = 11'h600;
    localparam logic [10:0] GUARD_HALF    = 11'h400;
    localparam logic [10:0] GUARD_ALL     = 11'h000;

    // Status byte field positions, unused-bit value and power-up guard value
    localparam int ST_PIN_EN   = 7;
    localparam int ST_GUARD_HI = 3;
    localparam int ST_GUARD_LO = 2;
    localparam int ST_LATCH    = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [1:0] GUARD_RESET  = 2'h0;

    // Bit counter value of the eighth bit of a byte
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Pin synchroniser reset: deselected, clock low, protect pin high
    localparam logic [3:0] PIN_RESET = 4'h9;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_OPCODE = 3'b001,
        S_ADDR   = 3'b010,
        S_WDATA  = 3'b011,
        S_RDATA  = 3'b100,
        S_SWRITE = 3'b101,
        S_STOUT  = 3'b110,
        S_IGNORE = 3'b111
    } sfc_state_t;

endpackage

// >>> src/sfc_sync.sv
/*
 * Two flip-flop synchroniser for a group of independent pin levels.
 * Assumes each bit is a slow level relative to clk_sys.
 */
`timescale 1ns/1ns
module sfc_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule
